// >>> dshp_top.sv
// dual serial host port: spi mode 0 or i2c slave, chosen by a strap
`timescale 1ns/1ns
// What this block does
// - The spi slave port samples its serial clock on the 10 MHz system clock, so it works only well below the 30 MHz pin limit.
// - Spi uses clock polarity 0 and phase 0 only, sampling on rising and shifting on falling.
// - A low or floating mode strap selects the spi slave interface.
// - A mode strap tied high selects the i2c slave interface.
// - The i2c slave port samples its bus clock on the 10 MHz system clock, so it works only well below the 3.4 MHz pin limit.
// - The i2c port uses one engine for all modes, but its 10 MHz sampling cannot follow high-speed mode clocks.
// - The i2c slave answers address 01000 followed by the two address strap bits.
// - In i2c mode the mosi pin is address strap bit 0 and the select pin is bit 1.
// - In i2c mode the spi clock pin is the i2c clock and the miso pin is the i2c data line.
// - A pending event drives the interrupt output low, otherwise it stays high.
// - The power-down input is active low and holds the port idle while low.
module dshp_top
   import dshp_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // straps and power
   input  wire logic       mode_strap,
   input  wire logic       power_down_n,
   // shared serial pins
   input  wire logic       sclk_or_scl_pin,
   input  wire logic       mosi_or_addr_lo_pin,
   input  wire logic       select_or_addr_hi_pin,
   input  wire logic       miso_sda_in,
   output logic            miso_sda_out,
   output logic            miso_sda_oe,
   // interrupt
   output logic            int_n,
   // internal side
   input  wire logic       event_pulse,
   input  wire logic       event_clear,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      rx_byte,
   output logic            rx_valid,
   output logic            i2c_mode,
   output logic            powered_down
);
   import dshp_pkg::*;

   logic rst_sync1_q;
   logic rst_sync2_q;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end
      else
      begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end
   assign rst_n = rst_sync2_q;

   logic clk_s;
   logic mosi_s;
   logic cs_s;
   logic sda_s;
   logic mode_s;
   logic pd_n_s;

   dshp_sync u_sync_clk  (.clk(sys_clk), .rst_n(rst_n), .din(sclk_or_scl_pin), .dout(clk_s));
   dshp_sync u_sync_mosi (.clk(sys_clk), .rst_n(rst_n), .din(mosi_or_addr_lo_pin), .dout(mosi_s));
   dshp_sync u_sync_cs   (.clk(sys_clk), .rst_n(rst_n), .din(select_or_addr_hi_pin), .dout(cs_s));
   dshp_sync u_sync_sda  (.clk(sys_clk), .rst_n(rst_n), .din(miso_sda_in), .dout(sda_s));
   dshp_sync u_sync_mode (.clk(sys_clk), .rst_n(rst_n), .din(mode_strap), .dout(mode_s));
   // synchronised inverted so the idle-high reset value reads as powered down,
   // avoiding a false wake-up before the filter has flushed
   logic pd_s;
   dshp_sync u_sync_pd   (.clk(sys_clk), .rst_n(rst_n), .din(!power_down_n), .dout(pd_s));
   assign pd_n_s = !pd_s;

   // straps latched while powered down; held through operation
   logic       mode_q;
   logic [1:0] addr_strap_bits_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q            <= 1'b0;
         addr_strap_bits_q <= 2'h0;
      end
      else if (!pd_n_s)
      begin
         mode_q            <= mode_s;
         addr_strap_bits_q <= {cs_s, mosi_s};
      end
   end

   logic active;
   assign active = pd_n_s;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         i2c_mode     <= 1'b0;
         powered_down <= 1'b1;
      end
      else
      begin
         i2c_mode     <= mode_q;
         powered_down <= !pd_n_s;
      end
   end

   // edges of the serial clock; the sampled clock limits real rates well below
   // the pin maxima, a known trade for an all-synchronous design
   logic clk_d1_q;
   logic sda_d1_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // matches the synchroniser's idle-high reset, so no false edge follows reset
         clk_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end
      else
      begin
         clk_d1_q <= clk_s;
         sda_d1_q <= sda_s;
      end
   end
   logic clk_rise;
   logic clk_fall;
   assign clk_rise = clk_s && !clk_d1_q;
   assign clk_fall = !clk_s && clk_d1_q;

   // ---------------- spi mode 0 ----------------
   logic [7:0] spi_sh_q;
   logic [7:0] spi_tx_q;
   logic [2:0] spi_cnt_q;
   logic       spi_sel;
   logic       spi_byte_done;
   assign spi_sel = active && !mode_q && !cs_s;
   assign spi_byte_done = spi_sel && clk_rise && (spi_cnt_q == 3'h7);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         spi_sh_q  <= TX_RESET;
         spi_cnt_q <= 3'h0;
         spi_tx_q  <= TX_RESET;
      end
      else if (!spi_sel)
      begin
         spi_cnt_q <= 3'h0;
         spi_tx_q  <= tx_byte;
      end
      else if (clk_rise)
      begin
         spi_sh_q  <= {spi_sh_q[6:0], mosi_s};
         spi_cnt_q <= spi_cnt_q + 3'h1;
      end
      else if (clk_fall)
      begin
         if (spi_cnt_q == 3'h0)
            spi_tx_q <= tx_byte;
         else
            spi_tx_q <= {spi_tx_q[6:0], 1'b0};
      end
   end

   // ---------------- i2c slave ----------------
   dshp_i2c_state_t st_q;
   logic [7:0] i2c_sh_q;
   logic [3:0] i2c_cnt_q;
   logic       i2c_rd_q;
   logic       i2c_ack_q;
   logic [7:0] i2c_tx_q;
   logic       i2c_start;
   logic       i2c_stop;
   logic       i2c_byte_done;
   logic [6:0] my_addr;
   assign i2c_start = active && mode_q && clk_s && sda_d1_q && !sda_s;
   assign i2c_stop  = active && mode_q && clk_s && !sda_d1_q && sda_s;
   assign my_addr = {I2C_ADDR_HI, addr_strap_bits_q};
   assign i2c_byte_done = (st_q == DSHP_DATA) && !i2c_rd_q && clk_rise
                          && (i2c_cnt_q == 4'h7);

   // one edge-driven engine for all speed modes, fit only for bus clocks well below the 10 MHz sampling rate
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q      <= DSHP_IDLE;
         i2c_sh_q  <= 8'h00;
         i2c_cnt_q <= 4'h0;
         i2c_rd_q  <= 1'b0;
         i2c_ack_q <= 1'b0;
         i2c_tx_q  <= TX_RESET;
      end
      else if (!active || !mode_q || i2c_stop)
      begin
         st_q      <= DSHP_IDLE;
         i2c_ack_q <= 1'b0;
      end
      else if (i2c_start)
      begin
         st_q      <= DSHP_ADDR;
         i2c_cnt_q <= 4'h0;
         i2c_ack_q <= 1'b0;
      end
      // scl pin clocks the data line
      else if (clk_rise)
      begin
         if (i2c_cnt_q < 4'h8)
         begin
            i2c_sh_q  <= {i2c_sh_q[6:0], sda_s};
            i2c_cnt_q <= i2c_cnt_q + 4'h1;
         end
         else
         begin
            // ninth bit: master ack on reads ends the byte stream on nack
            i2c_cnt_q <= 4'h0;
            if (st_q == DSHP_DATA && i2c_rd_q && sda_s)
               st_q <= DSHP_IDLE;
         end
      end
      else if (clk_fall)
      begin
         case (st_q)
            DSHP_IDLE:
               i2c_ack_q <= 1'b0;
            DSHP_ADDR:
            begin
               if (i2c_cnt_q == 4'h8)
               begin
                  if (i2c_sh_q[7:1] == my_addr)
                  begin
                     i2c_ack_q <= 1'b1;
                     i2c_rd_q  <= i2c_sh_q[0];
                  end
                  else
                     st_q <= DSHP_IDLE;
               end
               else if (i2c_cnt_q == 4'h0 && i2c_ack_q)
               begin
                  i2c_ack_q <= 1'b0;
                  st_q      <= DSHP_DATA;
                  i2c_tx_q  <= tx_byte;
               end
            end
            DSHP_DATA:
            begin
               if (i2c_cnt_q == 4'h8)
                  i2c_ack_q <= !i2c_rd_q;
               else if (i2c_cnt_q == 4'h0)
               begin
                  i2c_ack_q <= 1'b0;
                  if (i2c_rd_q)
                     i2c_tx_q <= tx_byte;
               end
               else if (i2c_rd_q)
                  i2c_tx_q <= {i2c_tx_q[6:0], 1'b0};
            end
            default:
               st_q <= DSHP_IDLE;
         endcase
      end
   end

   // open-drain drive: low only for ack or a read zero
   logic sda_low;
   assign sda_low = i2c_ack_q
                    || ((st_q == DSHP_DATA) && i2c_rd_q && (i2c_cnt_q < 4'h8) && !i2c_tx_q[7]);

   // miso pin shared between spi data and i2c sda
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         miso_sda_out <= 1'b0;
         miso_sda_oe  <= 1'b0;
      end
      else if (mode_q)
      begin
         miso_sda_out <= 1'b0;
         miso_sda_oe  <= active && sda_low;
      end
      else
      begin
         miso_sda_out <= spi_tx_q[7];
         miso_sda_oe  <= spi_sel;
      end
   end

   // received bytes from either link
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_byte  <= 8'h00;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= spi_byte_done || i2c_byte_done;
         if (spi_byte_done)
            rx_byte <= {spi_sh_q[6:0], mosi_s};
         else if (i2c_byte_done)
            rx_byte <= {i2c_sh_q[6:0], sda_s};
      end
   end

   // sticky event, set wins over clear
   logic evt_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         evt_q <= 1'b0;
      else if (event_pulse)
         evt_q <= 1'b1;
      else if (event_clear)
         evt_q <= 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         int_n <= 1'b1;
      else
         int_n <= !evt_q;
   end
endmodule

// >>> dshp_pkg.sv
// constants and types shared by the dual serial host port
package dshp_pkg;
   localparam int unsigned SYS_CLK_HZ       = 10000000;
   localparam int unsigned SPI_MAX_HZ       = 30000000;
   localparam int unsigned I2C_MAX_HZ       = 3400000;
   localparam logic [4:0]  I2C_ADDR_HI      = 5'h08;
   localparam int          I2C_ADDR_W       = 7;
   localparam int          BYTE_W           = 8;
   localparam logic [7:0]  TX_RESET         = 8'h00;
   localparam logic [7:0]  EVT_RESET        = 8'h00;
   localparam int          SYNC_STAGES      = 3;

   typedef enum logic [2:0]
   {
      DSHP_IDLE = 3'h1,
      DSHP_ADDR = 3'h2,
      DSHP_DATA = 3'h4
   } dshp_i2c_state_t;
endpackage

// >>> dshp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module dshp_sync
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // raw and filtered level
   input  wire logic din,
   output logic      dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dout <= 1'b1;
      else if (s2_q == s3_q)
         dout <= s3_q;
   end
endmodule

// >>> dshp_sva.sv
// checker for the dual serial host port
`timescale 1ns/1ns
module dshp_sva
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // pins and internal side
   input wire logic power_down_n,
   input wire logic select_or_addr_hi_pin,
   input wire logic miso_sda_out,
   input wire logic miso_sda_oe,
   input wire logic int_n,
   input wire logic event_pulse,
   input wire logic event_clear,
   input wire logic rx_valid,
   input wire logic i2c_mode,
   input wire logic powered_down
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   AST_INT_SET: assert property (event_pulse |-> ##[1:2] !int_n)
      else $error("int_n late");
   AST_INT_CAUSE: assert property ($fell(int_n) |->
      $past(event_pulse) || $past(event_pulse, 2)) else $error("int_n fell alone");
   AST_INT_CLEAR: assert property ($rose(int_n) |->
      $past(event_clear) || $past(event_clear, 2)) else $error("int_n rose alone");
   AST_PD_SYNC: assert property (!power_down_n [*8] |-> powered_down)
      else $error("power-down missed");
   AST_PD_IDLE: assert property (powered_down [*2] |-> !miso_sda_oe && !rx_valid)
      else $error("port busy in power-down");
   AST_MODE_HOLD: assert property (!powered_down [*3] |-> $stable(i2c_mode))
      else $error("mode moved while running");
   AST_I2C_LOW: assert property (i2c_mode && miso_sda_oe |-> !miso_sda_out)
      else $error("sda driven high");
   AST_CS_IDLE: assert property ((!i2c_mode && select_or_addr_hi_pin) [*8]
      |-> !miso_sda_oe) else $error("miso driven unselected");
   AST_CS_DRIVE: assert property ((!i2c_mode && !powered_down && !select_or_addr_hi_pin) [*8]
      |-> miso_sda_oe) else $error("miso not driven");
   cover property (rx_valid && !i2c_mode);
   cover property (rx_valid && i2c_mode);
   cover property ($rose(int_n));
endmodule

bind dshp_top dshp_sva u_sva (.sys_clk, .reset_n, .power_down_n, .select_or_addr_hi_pin,
   .miso_sda_out, .miso_sda_oe, .int_n, .event_pulse, .event_clear, .rx_valid, .i2c_mode,
   .powered_down);

// >>> dshp_host.sv
// host master model for the shared spi and i2c pins
`timescale 1ns/1ns
module dshp_host
(
   // pins driven by the host
   output logic sclk,
   output logic mosi,
   output logic sel,
   output logic sda_low,
   // resolved data wire
   input  wire logic sda
);
   // clock idles low; released lines sit at the pull-up
   initial
   begin
      sclk = 1'b0;
      mosi = 1'b1;
      sel = 1'b1;
      sda_low = 1'b0;
   end
   // 800 ns clock, data set before each rise, msb first
   task automatic spi_frame(input logic [7:0] tx, output logic [7:0] rx);
      sel = 1'b0;
      #1000;
      for (int i = 7; i >= 0; i--)
      begin
         mosi = tx[i];
         #400 sclk = 1'b1;
         // the sampled slave shifts late, so read at the end of the high phase
         #390 rx[i] = sda;
         #10 sclk = 1'b0;
      end
      sel = 1'b1;
      mosi = 1'b1;
   endtask
   // slow bit; sda only moves while scl is low, straps untouched
   task automatic i2c_bit(input logic b, output logic r);
      #300 sda_low = !b;
      #500 sclk = 1'b1;
      #400 r = sda;
      #400 sclk = 1'b0;
   endtask
   task automatic i2c_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         i2c_bit(b[i], r);
      i2c_bit(1'b1, r);
      ack = !r;
   endtask
   task automatic i2c_start;
      #800 sda_low = 1'b1;
      #800 sclk = 1'b0;
   endtask
   task automatic i2c_stop;
      #300 sda_low = 1'b1;
      #500 sclk = 1'b1;
      #800 sda_low = 1'b0;
      #800;
   endtask
endmodule

// >>> dshp_tb.sv
// self-checking bench for the dual serial host port
`timescale 1ns/1ns
module tb;
   logic       sys_clk = 1'b0;
   logic       reset_n, mode_strap, power_down_n, event_pulse, event_clear;
   logic       sclk, mosi, sel, sda_low, out, oe, int_n, rx_valid, i2c_mode, powered_down;
   logic [7:0] tx_byte, rx_byte, got_rx, rx, exp_tx [3], exp_rx [3];
   int         n_rx = 0, n_fail = 0, samples_checked = 0, cycles = 0;
   // open-drain data wire with its pull-up
   wire        sda = (oe ? out : 1'b1) & !sda_low;

   always #50 sys_clk = !sys_clk;

   dshp_top DUT (.sys_clk, .reset_n, .mode_strap, .power_down_n, .sclk_or_scl_pin(sclk),
      .mosi_or_addr_lo_pin(mosi), .select_or_addr_hi_pin(sel), .miso_sda_in(sda),
      .miso_sda_out(out), .miso_sda_oe(oe), .int_n, .event_pulse, .event_clear, .tx_byte,
      .rx_byte, .rx_valid, .i2c_mode, .powered_down);
   dshp_host u_host (.sclk, .mosi, .sel, .sda_low, .sda);

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1)
      begin
         got_rx <= rx_byte;
         n_rx <= n_rx + 1;
      end
      if (cycles == 20000)
      begin
         n_fail++;
         finish_test();
      end
   end

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask
   // straps only latch in power-down
   task automatic pd_cycle(input logic m, input logic [1:0] s);
      @(negedge sys_clk);
      mode_strap = m;
      u_host.mosi = s[0];
      u_host.sel = s[1];
      u_host.sclk = m;
      power_down_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk1("powered_down", 1'b1, powered_down);
      power_down_n = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk1("powered_down", 1'b0, powered_down);
      chk1("i2c_mode", m, i2c_mode);
   endtask
   task automatic t_int;
      @(negedge sys_clk) event_pulse = 1'b1;
      @(negedge sys_clk) event_pulse = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk1("int_n", 1'b0, int_n);
      event_pulse = 1'b1;
      event_clear = 1'b1;
      @(negedge sys_clk) event_pulse = 1'b0;
      event_clear = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk1("int_n", 1'b0, int_n);
      event_clear = 1'b1;
      @(negedge sys_clk) event_clear = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk1("int_n", 1'b1, int_n);
      $display("test interrupt done");
   endtask
   task automatic t_spi;
      exp_tx = '{8'hA5, 8'h00, 8'h81};
      exp_rx = '{8'h3C, 8'hFF, 8'h7E};
      for (int i = 0; i < 3; i++)
      begin
         tx_byte = exp_tx[i];
         u_host.spi_frame(exp_rx[i], rx);
         repeat (10) @(negedge sys_clk);
         chk8("miso", exp_tx[i], rx);
         chk8("rx_byte", exp_rx[i], got_rx);
      end
      $display("test spi done");
   endtask
   task automatic t_i2c;
      logic ack;
      int   n0;
      for (int a = 0; a < 4; a++)
      begin
         pd_cycle(1'b1, a[1:0]);
         u_host.i2c_start();
         u_host.i2c_byte({5'h08, a[1:0], 1'b0}, ack);
         chk1("address ack", 1'b1, ack);
         u_host.i2c_byte(8'hC0 | a[7:0], ack);
         chk1("data ack", 1'b1, ack);
         u_host.i2c_stop();
         chk8("rx_byte", 8'hC0 | a[7:0], got_rx);
         n0 = n_rx;
         u_host.i2c_start();
         u_host.i2c_byte({5'h08, a[1:0] ^ 2'h1, 1'b0}, ack);
         chk1("other address ack", 1'b0, ack);
         u_host.i2c_stop();
         chk8("rx count", n0[7:0], n_rx[7:0]);
      end
      tx_byte = 8'h5A;
      u_host.i2c_start();
      u_host.i2c_byte({5'h08, 2'h3, 1'b1}, ack);
      chk1("read address ack", 1'b1, ack);
      for (int i = 7; i >= 0; i--)
         u_host.i2c_bit(1'b1, rx[i]);
      u_host.i2c_bit(1'b1, ack);
      u_host.i2c_stop();
      chk8("i2c read", 8'h5A, rx);
      $display("test i2c done");
   endtask
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      reset_n = 1'b0;
      power_down_n = 1'b0;
      mode_strap = 1'b0;
      event_pulse = 1'b0;
      event_clear = 1'b0;
      tx_byte = 8'h00;
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      pd_cycle(1'b0, 2'h3);
      t_int();
      t_spi();
      t_i2c();
      finish_test();
   end
endmodule
